// File: hdl/eclk_pkg.sv
package eclk_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned MCLK_PERIOD_NS = 10;     // 100 MHz system clock
  localparam int unsigned LF_FREQ_HZ     = 32000;  // External low-frequency clock rate
  localparam int unsigned LF_PERIOD_NS   = 1_000_000_000 / LF_FREQ_HZ;
  // Monitor waits two low-frequency periods before calling the clock dead
  localparam int unsigned LFMON_TIMEOUT_CYC = (2 * LF_PERIOD_NS) / MCLK_PERIOD_NS;
  localparam int unsigned LFMON_W           = 13;

  // ==========================================================================
  // Divider and counter shapes
  // ==========================================================================
  localparam int unsigned CO_DIV_W          = 3;   // Ratio = 2 * (code + 1)
  localparam int unsigned FCNT_CNT_W        = 24;
  localparam int unsigned FCNT_PER_W        = 8;
  localparam int unsigned FCNT_TRIG_PERIODS = 1;   // Trigger periods per capture

  // ==========================================================================
  // Source selections
  // ==========================================================================
  typedef enum logic [1:0] {
    ECLK_LF_INT,
    ECLK_LF_XTAL,
    ECLK_LF_EXT
  } eclk_lf_src_t;

  typedef enum logic [1:0] {
    ECLK_CO_INTERNAL_SYSTEM_OSCILLATOR,
    ECLK_CO_ULP,
    ECLK_CO_LF
  } eclk_co_src_t;

  typedef enum logic [1:0] {
    ECLK_FC_MAIN,
    ECLK_FC_INTERNAL_SYSTEM_OSCILLATOR,
    ECLK_FC_CLKOUT,
    ECLK_FC_EXTIN
  } eclk_fc_src_t;

  typedef enum logic [1:0] {
    ECLK_F_IDLE,
    ECLK_F_ARM,
    ECLK_F_COUNT
  } eclk_fst_t;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  // Raw clock levels, sampled on mclk
  typedef struct packed {
    logic internal_low_freq_oscillator;
    logic low_freq_crystal_oscillator;
    logic ext_low_freq_clock_input;
    logic ext_high_freq_clock_input;
    logic hf_crystal;
    logic hs_alt_source;
    logic internal_system_oscillator;
    logic ultra_low_power_bus_clock;
    logic fcnt_reference;
    logic external_counter_input;
  } eclk_clkin_t;

  // Software control bits from the system control unit
  typedef struct packed {
    logic                select_ext_low_freq_bit;
    logic                low_freq_crystal_oscillator_started;
    logic                lf_monitor_enable;
    logic                select_ext_high_freq_bit;
    logic                high_speed_source_select_bit;
    logic                main_clock_use_high_speed_bit;
    logic                clkout_enable;
    eclk_co_src_t        clkout_source;
    logic [CO_DIV_W-1:0] clkout_divide;
    logic                clkout_to_counter;
    logic                fcnt_start;
    eclk_fc_src_t        fcnt_source;
    logic                fcnt_trigger_external;
  } eclk_ctrl_t;

  // Frequency counter state
  typedef struct packed {
    eclk_fst_t             fst;
    logic [FCNT_CNT_W-1:0] cnt;
    logic [FCNT_PER_W-1:0] per;
    logic                  src_prev;
    logic                  trig_prev;
    logic [FCNT_CNT_W-1:0] result;
    logic                  done;
    logic                  busy;
    logic                  conflict;
  } eclk_fcnt_state_t;

  // Pick one of three levels by a two-bit code
  function automatic logic eclk_pick3(input logic [1:0] sel, input logic a, input logic b,
                                      input logic c);
    logic r;
    r = a;
    if (sel == 2'h1) begin
      r = b;
    end else if (sel == 2'h2) begin
      r = c;
    end
    return r;
  endfunction

endpackage

// File: hdl/eclk_freq_counter.sv
module eclk_freq_counter
  import eclk_pkg::*;
#(
  parameter int unsigned CNT_W        = FCNT_CNT_W,
  parameter int unsigned TRIG_PERIODS = FCNT_TRIG_PERIODS
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_b,
  // Request
  input  wire logic             start,
  input  wire logic             conflict_in,
  input  wire logic             src_level,
  input  wire logic             trig_level,
  // Answer
  output logic [CNT_W-1:0]      result,
  output logic                  done,
  output logic                  busy,
  output logic                  conflict
);

  // ==========================================================================
  // State
  // ==========================================================================
  eclk_fcnt_state_t s;
  eclk_fcnt_state_t next_s;
  logic             src_rise;
  logic             trig_rise;

  assign src_rise  = src_level && !s.src_prev;
  assign trig_rise = trig_level && !s.trig_prev;

  // Capture: arm on start, then from a trigger edge count source edges over a fixed window
  always_comb begin
    next_s           = s;
    next_s.src_prev  = src_level;
    next_s.trig_prev = trig_level;
    next_s.done      = 1'b0;
    unique case (s.fst)
      ECLK_F_IDLE: begin
        if (start && conflict_in) begin
          next_s.conflict = 1'b1;  // Shared pin in both roles: refused
        end else if (start) begin
          next_s.conflict = 1'b0;
          next_s.busy     = 1'b1;
          next_s.fst      = ECLK_F_ARM;
        end
      end
      ECLK_F_ARM: begin
        if (trig_rise) begin
          next_s.cnt = '0;
          next_s.per = '0;
          next_s.fst = ECLK_F_COUNT;
        end
      end
      ECLK_F_COUNT: begin
        if (src_rise) begin
          next_s.cnt = s.cnt + 1'b1;  // Count source periods
        end
        if (trig_rise) begin
          if (s.per == FCNT_PER_W'(TRIG_PERIODS - 1)) begin
            next_s.result = src_rise ? s.cnt + 1'b1 : s.cnt;
            next_s.done   = 1'b1;
            next_s.busy   = 1'b0;
            next_s.fst    = ECLK_F_IDLE;
          end else begin
            next_s.per = s.per + 1'b1;
          end
        end
      end
    endcase
  end

  // Registers
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign result   = s.result;
  assign done     = s.done;
  assign busy     = s.busy;
  assign conflict = s.conflict;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  property p_fcnt_refuse;
    (s.fst == ECLK_F_IDLE) && start && conflict_in |=> conflict && !busy;
  endproperty
  a_fcnt_refuse: assert property (p_fcnt_refuse) else $error("counter took a conflicting start");

  property p_fcnt_done_pulse;
    done |=> !done && !busy && (result == $past(result));
  endproperty
  a_fcnt_done_pulse: assert property (p_fcnt_done_pulse) else $error("done not a single pulse");

endmodule

// File: hdl/eclk_top.sv
// Operation
// - With crystal not started, the low-frequency monitor watches the external input.
// - External low-frequency selection locks; only boot reset returns to internal sources.
// - High-speed source select must pick the high-frequency clock before main clock use.
// - Use-high-speed bit switches the main clock onto the high-speed source.
// - Clearing use-high-speed returns to system oscillator; mux status flag clears on the same edge as the switch.
// - Clock output sources: system oscillator, ultra-low-power bus clock, low-frequency clock.
// - Clock output divides by even ratios 2 to 16, to pin or counter.
// - Counter counts source periods inside one fixed trigger period.
// - Counter measures main clock, system oscillator, clock output or external input.
module eclk_top
  import eclk_pkg::*;
#(
  parameter int unsigned LFMON_TIMEOUT = LFMON_TIMEOUT_CYC
) (
  // Clock and boot-level reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Clock levels and control bits
  input  wire eclk_clkin_t clk_in,
  input  wire eclk_ctrl_t  ctrl,
  // Generated clocks
  output logic             low_frequency_clock,
  output logic             high_frequency_clock,
  output logic             main_clock,
  output logic             clk_out_pin,
  // Status
  output logic             high_speed_mux_status_flag,
  output logic             lf_ext_locked,
  output logic             lf_monitor_ok,
  // Frequency counter
  output logic [FCNT_CNT_W-1:0] fcnt_result,
  output logic             fcnt_done,
  output logic             fcnt_busy,
  output logic             fcnt_conflict
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic                lf_locked;
    eclk_lf_src_t        lf_sel;
    logic                lf_out;
    logic                hf_sel;
    logic                hf_out;
    logic                hs_sel;
    logic                hs_out;
    logic                mc_sel;
    logic                mc_out;
    logic                mon_prev;
    logic [LFMON_W-1:0]  mon_cnt;
    logic                mon_ok;
    eclk_co_src_t        co_sel;
    logic                co_prev;
    logic [CO_DIV_W-1:0] co_cnt;
    logic                co_out;
    logic                pin_out;
  } eclk_state_t;

  eclk_state_t  s;
  eclk_state_t  next_s;
  eclk_lf_src_t lf_req;
  logic         lf_cur;
  logic         lf_new;
  logic         hf_cur;
  logic         hf_new;
  logic         hs_cur;
  logic         hs_new;
  logic         mc_cur;
  logic         mc_new;
  logic         mon_lvl;
  logic         mon_rise;
  logic         co_cur;
  logic         co_new;
  logic         co_rise;
  logic         fc_src_lvl;
  logic         fc_trig_lvl;
  logic         fc_conflict;

  // ==========================================================================
  // Source levels for each mux
  // ==========================================================================
  // Locked selection wins over any crystal or internal request
  always_comb begin
    lf_req = ECLK_LF_INT;
    if (s.lf_locked || ctrl.select_ext_low_freq_bit) begin
      lf_req = ECLK_LF_EXT;
    end else if (ctrl.low_freq_crystal_oscillator_started) begin
      lf_req = ECLK_LF_XTAL;
    end
  end

  assign lf_cur = eclk_pick3(s.lf_sel, clk_in.internal_low_freq_oscillator,
                             clk_in.low_freq_crystal_oscillator, clk_in.ext_low_freq_clock_input);
  assign lf_new = eclk_pick3(lf_req, clk_in.internal_low_freq_oscillator,
                             clk_in.low_freq_crystal_oscillator, clk_in.ext_low_freq_clock_input);
  assign hf_cur = s.hf_sel ? clk_in.ext_high_freq_clock_input : clk_in.hf_crystal;
  assign hf_new = ctrl.select_ext_high_freq_bit ? clk_in.ext_high_freq_clock_input
                                                : clk_in.hf_crystal;
  // High-speed path takes the high-frequency clock when selected
  assign hs_cur = s.hs_sel ? s.hf_out : clk_in.hs_alt_source;
  assign hs_new = ctrl.high_speed_source_select_bit ? s.hf_out : clk_in.hs_alt_source;
  assign mc_cur = s.mc_sel ? s.hs_out : clk_in.internal_system_oscillator;
  assign mc_new = ctrl.main_clock_use_high_speed_bit ? s.hs_out
                                                     : clk_in.internal_system_oscillator;
  // Monitor follows the external input unless the crystal was started
  assign mon_lvl  = ctrl.low_freq_crystal_oscillator_started ? clk_in.low_freq_crystal_oscillator
                                      : clk_in.ext_low_freq_clock_input;
  assign mon_rise = mon_lvl && !s.mon_prev;
  assign co_cur   = eclk_pick3(s.co_sel, clk_in.internal_system_oscillator,
                               clk_in.ultra_low_power_bus_clock, s.lf_out);
  assign co_new   = eclk_pick3(ctrl.clkout_source, clk_in.internal_system_oscillator,
                               clk_in.ultra_low_power_bus_clock, s.lf_out);
  assign co_rise  = co_cur && !s.co_prev;

  // ==========================================================================
  // Next state
  // ==========================================================================
  // Every mux moves only while old and new sources are both low
  always_comb begin
    next_s = s;
    // Low-frequency source, sticky once external
    if (ctrl.select_ext_low_freq_bit) begin
      next_s.lf_locked = 1'b1;
    end
    if ((s.lf_sel != lf_req) && !lf_cur && !lf_new) begin
      next_s.lf_sel = lf_req;
    end
    next_s.lf_out = lf_cur;
    // High-frequency source
    if ((s.hf_sel != ctrl.select_ext_high_freq_bit) && !hf_cur && !hf_new) begin
      next_s.hf_sel = ctrl.select_ext_high_freq_bit;
    end
    next_s.hf_out = hf_cur;
    // High-speed source frozen while the main clock may be using it
    if (!s.mc_sel && !ctrl.main_clock_use_high_speed_bit &&
        (s.hs_sel != ctrl.high_speed_source_select_bit) && !hs_cur && !hs_new) begin
      next_s.hs_sel = ctrl.high_speed_source_select_bit;
    end
    next_s.hs_out = hs_cur;
    // Main clock: set moves onto high speed, clear returns to oscillator
    if ((s.mc_sel != ctrl.main_clock_use_high_speed_bit) && !mc_cur && !mc_new) begin
      next_s.mc_sel = ctrl.main_clock_use_high_speed_bit;
    end
    next_s.mc_out = mc_cur;
    // Activity monitor; a dead input drops the flag after the timeout
    next_s.mon_prev = mon_lvl;
    if (!ctrl.lf_monitor_enable) begin
      next_s.mon_cnt = '0;
      next_s.mon_ok  = 1'b0;
    end else if (mon_rise) begin
      next_s.mon_cnt = '0;
      next_s.mon_ok  = 1'b1;
    end else if (s.mon_cnt == LFMON_W'(LFMON_TIMEOUT - 1)) begin
      next_s.mon_ok = 1'b0;
    end else begin
      next_s.mon_cnt = s.mon_cnt + 1'b1;
    end
    // Clock output: toggle every (code + 1) source edges, ratio 2 to 16
    next_s.co_prev = co_cur;
    if ((s.co_sel != ctrl.clkout_source) && !co_cur && !co_new) begin
      next_s.co_sel = ctrl.clkout_source;
    end
    if (!ctrl.clkout_enable) begin
      next_s.co_cnt = '0;
      next_s.co_out = 1'b0;
    end else if (co_rise) begin
      if (s.co_cnt >= ctrl.clkout_divide) begin
        next_s.co_cnt = '0;
        next_s.co_out = !s.co_out;
      end else begin
        next_s.co_cnt = s.co_cnt + 1'b1;
      end
    end
    // Pin sees the divided clock only when it is not routed to the counter
    next_s.pin_out = next_s.co_out && !ctrl.clkout_to_counter;
  end

  // Registers; this reset is the boot-level reset
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign low_frequency_clock        = s.lf_out;
  assign high_frequency_clock       = s.hf_out;
  assign main_clock                 = s.mc_out;
  assign clk_out_pin                = s.pin_out;
  assign high_speed_mux_status_flag = s.mc_sel;
  assign lf_ext_locked              = s.lf_locked;
  assign lf_monitor_ok              = s.mon_ok;

  // ==========================================================================
  // Frequency counter
  // ==========================================================================
  // Source choice among four clocks
  always_comb begin
    fc_src_lvl = s.mc_out;
    unique case (ctrl.fcnt_source)
      ECLK_FC_MAIN:   fc_src_lvl = s.mc_out;
      ECLK_FC_INTERNAL_SYSTEM_OSCILLATOR: fc_src_lvl = clk_in.internal_system_oscillator;
      ECLK_FC_CLKOUT: fc_src_lvl = s.co_out;
      ECLK_FC_EXTIN:  fc_src_lvl = clk_in.external_counter_input;
    endcase
  end

  assign fc_trig_lvl = ctrl.fcnt_trigger_external ? clk_in.external_counter_input
                                                  : clk_in.fcnt_reference;
  // The shared pin cannot serve both roles in one capture
  assign fc_conflict = ctrl.fcnt_trigger_external && (ctrl.fcnt_source == ECLK_FC_EXTIN);

  eclk_freq_counter #(
    .CNT_W        (FCNT_CNT_W),
    .TRIG_PERIODS (FCNT_TRIG_PERIODS)
  ) eclk_freq_counter_i (
    .mclk        (mclk),
    .rst_b       (rst_b),
    .start       (ctrl.fcnt_start),
    .conflict_in (fc_conflict),
    .src_level   (fc_src_lvl),
    .trig_level  (fc_trig_lvl),
    .result      (fcnt_result),
    .done        (fcnt_done),
    .busy        (fcnt_busy),
    .conflict    (fcnt_conflict)
  );

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  property p_lf_lock_sticky;
    s.lf_locked |=> s.lf_locked && lf_ext_locked;
  endproperty
  a_lf_lock_sticky: assert property (p_lf_lock_sticky) else $error("lock released");

  property p_lf_no_return;
    (s.lf_sel == ECLK_LF_EXT) |=> (s.lf_sel == ECLK_LF_EXT);
  endproperty
  a_lf_no_return: assert property (p_lf_no_return) else $error("left external source");

  property p_mc_switch_low;
    $changed(s.mc_sel) |-> !main_clock && !$past(mc_new);
  endproperty
  a_mc_switch_low: assert property (p_mc_switch_low) else $error("main clock glitch");

  property p_mux_flag_clear;
    s.mc_sel && !ctrl.main_clock_use_high_speed_bit && !s.hs_out &&
      !clk_in.internal_system_oscillator |=> !high_speed_mux_status_flag;
  endproperty
  a_mux_flag_clear: assert property (p_mux_flag_clear) else $error("flag did not clear");

  property p_hs_frozen;
    s.mc_sel |=> $stable(s.hs_sel);
  endproperty
  a_hs_frozen: assert property (p_hs_frozen) else $error("high-speed config moved");

  property p_mon_timeout;
    ctrl.lf_monitor_enable && !mon_rise &&
      (s.mon_cnt == LFMON_W'(LFMON_TIMEOUT - 1)) |=> !lf_monitor_ok;
  endproperty
  a_mon_timeout: assert property (p_mon_timeout) else $error("monitor missed timeout");

  property p_co_toggle;
    ctrl.clkout_enable && co_rise && (s.co_cnt >= ctrl.clkout_divide) |=>
      (s.co_out != $past(s.co_out)) && (s.co_cnt == '0);
  endproperty
  a_co_toggle: assert property (p_co_toggle) else $error("divider missed toggle");

  property p_co_hold;
    ctrl.clkout_enable && !co_rise |=> $stable(s.co_out);
  endproperty
  a_co_hold: assert property (p_co_hold) else $error("divider toggled without edge");

  c_mc_to_hs:   cover property (!s.mc_sel ##1 s.mc_sel);
  c_lf_locked:  cover property (s.lf_sel == ECLK_LF_EXT);
  c_fcnt_done:  cover property (fcnt_done);
  c_co_div16:   cover property (ctrl.clkout_enable && (ctrl.clkout_divide == 3'h7) && co_rise);

endmodule

// File: sim/eclk_top_bench.sv
module eclk_top_bench
  import eclk_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // Stimulus and observation
  // ==========================================================================
  logic                  mclk = 1'b0;
  logic                  rst_b;
  logic [9:0]            lv = '0;
  logic [9:0]            run;
  int                    half[10] = '{4, 20, 3, 2, 9, 6, 3, 4, 7, 5};
  int                    cnt[10]  = '{default: 0};
  eclk_clkin_t           clk_in;
  eclk_ctrl_t            ctrl;
  logic                  lfc;
  logic                  hfc;
  logic                  mainc;
  logic                  cpin;
  logic                  hs_flag;
  logic                  locked;
  logic                  mon_ok;
  logic [FCNT_CNT_W-1:0] f_result;
  logic                  f_done;
  logic                  f_busy;
  logic                  f_conflict;
  logic [7:0]            obs;
  int                    errors      = 0;
  int                    checks_done = 0;
  int                    srcper[3]   = '{4, 6, 10};
  int                    fexp[4]     = '{10, 10, 5, 5};

  assign clk_in = eclk_clkin_t'(lv);
  assign obs    = {locked, mon_ok, f_done, hs_flag, cpin, mainc, hfc, lfc};

  // Short monitor timeout keeps the dead-clock check brief
  eclk_top #(.LFMON_TIMEOUT(20)) eclk_top_i (
    .mclk                       (mclk),
    .rst_b                      (rst_b),
    .clk_in                     (clk_in),
    .ctrl                       (ctrl),
    .low_frequency_clock        (lfc),
    .high_frequency_clock       (hfc),
    .main_clock                 (mainc),
    .clk_out_pin                (cpin),
    .high_speed_mux_status_flag (hs_flag),
    .lf_ext_locked              (locked),
    .lf_monitor_ok              (mon_ok),
    .fcnt_result                (f_result),
    .fcnt_done                  (f_done),
    .fcnt_busy                  (f_busy),
    .fcnt_conflict              (f_conflict)
  );

  // 100 MHz clock
  always #5 mclk = ~mclk;

  // Source levels; a stopped source sits low, as a dead oscillator would
  always @(posedge mclk) begin
    #1;
    for (int i = 0; i < 10; i++) begin
      if (!run[i]) begin
        lv[i]  = 1'b0;
        cnt[i] = 0;
      end else if (cnt[i] == half[i] - 1) begin
        lv[i]  = ~lv[i];
        cnt[i] = 0;
      end else begin
        cnt[i]++;
      end
    end
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("BAD at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic step();
    @(posedge mclk);
    #1;
  endtask

  // Period in mclk cycles between the third and fourth rise, past any switch
  task automatic measure(input int s, input int exp);
    int n, r, c3;
    logic p;
    n = 0;
    r = 0;
    c3 = 0;
    p = 1'b1;
    while (r < 4) begin
      @(negedge mclk);
      n++;
      if (n > 4000) begin
        errors++;
        $display("BAD at %0t: clock stuck", $time);
        complete_run();
      end
      if (obs[s] === 1'b1 && p === 1'b0) begin
        r++;
        if (r == 3) c3 = n;
      end
      p = obs[s];
    end
    check(32'(n - c3), 32'(exp));
  endtask

  task automatic wait_lvl(input int s, input logic v, input int bound);
    int n;
    n = 0;
    while (obs[s] !== v && n < bound) begin
      @(negedge mclk);
      n++;
    end
    if (obs[s] !== v) begin
      errors++;
      $display("BAD at %0t: wait ran out", $time);
      complete_run();
    end
    check(32'(obs[s]), 32'(v));
  endtask

  task automatic fcc(input int src, input int exp);
    step();
    ctrl.fcnt_source = eclk_fc_src_t'(src);
    ctrl.fcnt_start  = 1'b1;
    step();
    ctrl.fcnt_start  = 1'b0;
    check(32'(f_busy), 32'h0000_0001);
    wait_lvl(5, 1'b1, 400);
    check(32'(f_result), 32'(exp));
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    run   = 10'h2ff;
    ctrl  = '0;
    rst_b = 1'b0;
    repeat (11) @(posedge mclk);
    @(negedge mclk);
    check({obs, 24'(f_result)}, 32'h0000_0000);
    step();
    rst_b = 1'b1;
    $display("reset test done");
    // Every source and every even ratio on the output pin
    ctrl.clkout_enable = 1'b1;
    for (int s = 0; s < 3; s++) begin
      for (int c = 0; c < 8; c++) begin
        step();
        ctrl.clkout_source = eclk_co_src_t'(s);
        ctrl.clkout_divide = 3'(c);
        measure(3, 2 * (c + 1) * srcper[s]);
      end
    end
    $display("clock output test done");
    // Counter on each source, output pin parked while it feeds the counter
    step();
    ctrl.clkout_source     = ECLK_CO_INTERNAL_SYSTEM_OSCILLATOR;
    ctrl.clkout_divide     = 3'h0;
    ctrl.clkout_to_counter = 1'b1;
    for (int s = 0; s < 4; s++) begin
      fcc(s, fexp[s]);
    end
    check(32'(cpin), 32'h0000_0000);
    step();
    ctrl.fcnt_source = ECLK_FC_EXTIN;
    ctrl.fcnt_trigger_external = 1'b1;
    ctrl.fcnt_start = 1'b1;
    step();
    ctrl.fcnt_start = 1'b0;
    step();
    check({30'h0, f_conflict, f_busy}, 32'h0000_0002);
    // External pin as trigger alone is accepted and clears the refusal
    fcc(1, 2);
    check(32'(f_conflict), 32'h0000_0000);
    step();
    ctrl.fcnt_trigger_external = 1'b0;
    $display("counter test done");
    // Monitor follows the external input while the crystal is not started
    ctrl.lf_monitor_enable = 1'b1;
    wait_lvl(6, 1'b1, 100);
    run = 10'h37f;
    wait_lvl(6, 1'b0, 200);
    run = 10'h2ff;
    $display("monitor test done");
    // High-frequency clock from the crystal, then from the external input
    measure(1, 12);
    step();
    ctrl.select_ext_high_freq_bit = 1'b1;
    measure(1, 6);
    // High-speed mux must settle on the high-frequency clock before the main clock takes it
    step();
    ctrl.high_speed_source_select_bit = 1'b1;
    repeat (20) step();
    ctrl.main_clock_use_high_speed_bit = 1'b1;
    wait_lvl(4, 1'b1, 100);
    measure(2, 6);
    step();
    ctrl.high_speed_source_select_bit = 1'b0;
    measure(2, 6);
    step();
    ctrl.main_clock_use_high_speed_bit = 1'b0;
    wait_lvl(4, 1'b0, 100);
    measure(2, 4);
    $display("main clock test done");
    // Crystal request is honoured while nothing is locked
    step();
    ctrl.low_freq_crystal_oscillator_started = 1'b1;
    run = 10'h3ff;
    measure(0, 14);
    step();
    ctrl.low_freq_crystal_oscillator_started = 1'b0;
    // External low-frequency selection locks until boot reset
    wait_lvl(6, 1'b1, 100);
    step();
    ctrl.select_ext_low_freq_bit = 1'b1;
    step();
    ctrl.select_ext_low_freq_bit = 1'b0;
    wait_lvl(7, 1'b1, 10);
    measure(0, 8);
    step();
    ctrl.low_freq_crystal_oscillator_started = 1'b1;
    run = 10'h3ff;
    measure(0, 8);
    step();
    ctrl.low_freq_crystal_oscillator_started = 1'b0;
    rst_b = 1'b0;
    repeat (2) step();
    rst_b = 1'b1;
    wait_lvl(7, 1'b0, 2);
    measure(0, 10);
    $display("lock test done");
    complete_run();
  end

endmodule
